// ===== rtl/pdwt_top.sv
// pci dma target window address translator, direct and map-table modes
//
// Notes on behaviour
// - window sg select bit clear gives direct mode, set gives table lookup.
// - direct address is translated base high bits then pci bits n-1..2.
// - base and pci bits merge by and-or, base low bits not masked.
// - physical address bits 39..33 always zero.
// - direct window maps to memory aligned on its own size.
// - table mode reads the physical page from a map entry in memory.
// - translated base is table start, upper in-window pci bits index it.
// - one map entry maps one 8KB pci page to one 8KB memory page.
// - map entry is a quadword, bit 0 is its valid flag.
// - entry bit 1 is physical bit 13, bits 21..1 give page number.
// - memory address is entry page number appended to pci page offset.
// - table has one 8-byte entry per 8KB of window size.
// - entry address is base bits 33..n-10 then pci bits n-1..13.
// - hit needs enabled window and pci bits above mask equal to base.
// - map entry with valid bit clear raises an invalid-entry exception.
//
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/10ps
module pdwt_top (
  input  wire logic                        CLK,
  input  wire logic                        ARST_N,
  input  wire logic [pdwt_pkg::REG_AW-1:0] REG_ADDR,
  input  wire logic [pdwt_pkg::REG_DW-1:0] REG_WDATA,
  input  wire logic                        REG_WR,
  input  wire logic                        REG_RD,
  output logic      [pdwt_pkg::REG_DW-1:0] REG_RDATA,
  input  wire logic                        REQ_VALID,
  input  wire logic [pdwt_pkg::PCI_AW-1:0] REQ_ADDR,
  output logic                             REQ_READY,
  output logic                             RSP_VALID,
  output logic      [pdwt_pkg::PHYS_W-1:0] RSP_ADDR,
  output logic      [1:0]                  RSP_STATUS,
  output logic                             MEM_REQ,
  output logic      [pdwt_pkg::MEM_AW-1:0] MEM_ADDR,
  input  wire logic                        MEM_ACK,
  input  wire logic [pdwt_pkg::MEM_DW-1:0] MEM_RDATA
);

  // contiguous low-order ones, all zero through all ones
  function automatic logic mask_ok_f(input logic [11:0] m);
    mask_ok_f = ((m & (m + 12'h001)) == 12'h000);
  endfunction

  // memory holds only the lowest 8GB
  function automatic logic [pdwt_pkg::PHYS_W-1:0] phys_f(input logic [pdwt_pkg::MEM_AW-1:0] a);
    phys_f = {7'h00, a[pdwt_pkg::PHYS_ZERO_LSB-1:0]};
  endfunction

  // lowest enabled hitting window wins
  function automatic logic [1:0] pick_f(input logic [pdwt_pkg::NUM_WIN-1:0] h);
    pick_f = h[0] ? 2'h0 : h[1] ? 2'h1 : h[2] ? 2'h2 : 2'h3;
  endfunction

  logic [pdwt_pkg::RF_DEPTH-1:0][pdwt_pkg::REG_DW-1:0] words;
  pdwt_pkg::pdwt_win_s [pdwt_pkg::NUM_WIN-1:0] win;
  logic [pdwt_pkg::NUM_WIN-1:0] hit_vec;

  pdwt_pkg::pdwt_state_e        state_reg;
  pdwt_pkg::pdwt_state_e        state_next;
  logic [pdwt_pkg::PCI_AW-1:0]  ad_reg;
  logic [pdwt_pkg::PCI_AW-1:0]  ad_next;
  logic                         ready_reg;
  logic                         ready_next;
  logic                         mem_req_reg;
  logic                         mem_req_next;
  logic [pdwt_pkg::MEM_AW-1:0]  mem_addr_reg;
  logic [pdwt_pkg::MEM_AW-1:0]  mem_addr_next;
  logic [21:0]                  pte_reg;
  logic [21:0]                  pte_next;
  pdwt_pkg::pdwt_rsp_s          rsp_reg;
  pdwt_pkg::pdwt_rsp_s          rsp_next;
  logic                         rsp_valid_reg;
  logic                         rsp_valid_next;
  logic [2:0]                   sticky_reg;
  logic [2:0]                   sticky_next;

  // per-window decode and hit compare
  genvar gw;
  generate
    for (gw = 0; gw < pdwt_pkg::NUM_WIN; gw++) begin : g_win
      assign win[gw].base = words[gw*4+0][pdwt_pkg::WIN_MSB:pdwt_pkg::WIN_LSB];
      assign win[gw].en = words[gw*4+0][pdwt_pkg::WB_EN_BIT];
      assign win[gw].sg = words[gw*4+0][pdwt_pkg::WB_SG_BIT];
      assign win[gw].mask = words[gw*4+1][pdwt_pkg::WIN_MSB:pdwt_pkg::WIN_LSB];
      assign win[gw].tbase = words[gw*4+2][pdwt_pkg::REG_DW-1:pdwt_pkg::TB_REG_LSB];
      assign hit_vec[gw] = win[gw].en &&
        (((ad_reg[pdwt_pkg::WIN_MSB:pdwt_pkg::WIN_LSB] ^ win[gw].base) & ~win[gw].mask) == 12'h000);
    end
  endgenerate

  wire                         any_hit = |hit_vec;
  wire [1:0]                   sel_idx = pick_f(hit_vec);
  pdwt_pkg::pdwt_win_s         sel;
  assign sel = win[sel_idx];
  wire                         sel_mask_ok = mask_ok_f(sel.mask);
  wire [11:0]                  ad_hi_masked = ad_reg[pdwt_pkg::WIN_MSB:pdwt_pkg::WIN_LSB] & sel.mask;

  // direct: base bits 33..20 or-ed with in-window pci bits, no masking of base
  wire [pdwt_pkg::MEM_AW-1:0] direct_addr = {sel.tbase[23:10], 20'h00000} |
                                           {2'b00, ad_hi_masked, ad_reg[19:2], 2'b00};
  // map entry address: table base or-ed with page index times 8 bytes
  wire [pdwt_pkg::MEM_AW-1:0] pte_addr = {sel.tbase, 10'h000} |
                                        {12'h000, ad_hi_masked, ad_reg[19:pdwt_pkg::PAGE_LSB], 3'b000};
  // page number from entry bits 21..1 appended to page offset
  wire [pdwt_pkg::MEM_AW-1:0] sg_addr = {pte_next[pdwt_pkg::PTE_PAGE_MSB:pdwt_pkg::PTE_PAGE_LSB],
                                        ad_reg[pdwt_pkg::PAGE_LSB-1:2], 2'b00};
  wire                         ack_take = (state_reg == pdwt_pkg::ST_FETCH) && MEM_ACK && !mem_req_reg;
  wire                         pte_valid = MEM_RDATA[pdwt_pkg::PTE_VALID_BIT];

  // translation sequencer
  always_comb begin
    state_next = state_reg;
    ad_next = ad_reg;
    mem_req_next = 1'b0;
    mem_addr_next = mem_addr_reg;
    pte_next = pte_reg;
    rsp_next = rsp_reg;
    case (state_reg)
      pdwt_pkg::ST_IDLE: begin
        if (REQ_VALID && ready_reg) begin
          ad_next = REQ_ADDR;
          state_next = pdwt_pkg::ST_LOOK;
        end
      end
      pdwt_pkg::ST_LOOK: begin
        state_next = pdwt_pkg::ST_DONE;
        if (!any_hit) begin
          rsp_next = '{addr: '0, status: pdwt_pkg::RSP_MISS};
        end else if (!sel_mask_ok) begin
          rsp_next = '{addr: '0, status: pdwt_pkg::RSP_UNSUP};
        end else if (sel.sg) begin
          state_next = pdwt_pkg::ST_FETCH;
          mem_req_next = 1'b1;
          mem_addr_next = pte_addr;
        end else begin
          rsp_next = '{addr: phys_f(direct_addr), status: pdwt_pkg::RSP_OK};
        end
      end
      pdwt_pkg::ST_FETCH: begin
        if (ack_take) begin
          pte_next = MEM_RDATA[21:0];
          state_next = pdwt_pkg::ST_DONE;
          if (pte_valid) begin
            rsp_next = '{addr: phys_f(sg_addr), status: pdwt_pkg::RSP_OK};
          end else begin
            rsp_next = '{addr: '0, status: pdwt_pkg::RSP_INVALID};
          end
        end
      end
      pdwt_pkg::ST_DONE: begin
        state_next = pdwt_pkg::ST_IDLE;
      end
      default: begin
        state_next = pdwt_pkg::ST_IDLE;
      end
    endcase
  end

  assign ready_next = (state_next == pdwt_pkg::ST_IDLE);
  assign rsp_valid_next = (state_next == pdwt_pkg::ST_DONE);

  // register bus decode
  wire        bus_aligned = (REG_ADDR[1:0] == 2'b00);
  wire        in_win_area = bus_aligned && (REG_ADDR < pdwt_pkg::OFF_STATUS);
  wire [1:0]  slot = REG_ADDR[3:2];
  wire [pdwt_pkg::RF_AW-1:0] rf_idx = REG_ADDR[5:2];
  wire [pdwt_pkg::REG_DW-1:0] slot_mask = (slot == pdwt_pkg::SLOT_WBASE) ? pdwt_pkg::WMASK_WBASE :
                                          (slot == pdwt_pkg::SLOT_WMASK) ? pdwt_pkg::WMASK_WMASK :
                                          (slot == pdwt_pkg::SLOT_TBASE) ? pdwt_pkg::WMASK_TBASE : '0;
  wire        st_hit = bus_aligned && (REG_ADDR == pdwt_pkg::OFF_STATUS);
  wire        last_hit = bus_aligned && (REG_ADDR == pdwt_pkg::OFF_LAST_ADDR);
  wire [pdwt_pkg::REG_DW-1:0] status_word = {28'h0000000, sticky_reg, state_reg != pdwt_pkg::ST_IDLE};
  wire [pdwt_pkg::REG_DW-1:0] ext_word = st_hit ? status_word :
                                         last_hit ? rsp_reg.addr[33:2] : '0;

  // sticky event bits, write one to clear, a new event wins
  wire [2:0]  ev_set = {rsp_valid_next && rsp_next.status == pdwt_pkg::RSP_UNSUP,
                        rsp_valid_next && rsp_next.status == pdwt_pkg::RSP_MISS,
                        rsp_valid_next && rsp_next.status == pdwt_pkg::RSP_INVALID};
  wire [2:0]  ev_clr = (REG_WR && st_hit) ? REG_WDATA[pdwt_pkg::ST_UNSUP:pdwt_pkg::ST_INVALID] : 3'b000;
  assign sticky_next = (sticky_reg & ~ev_clr) | ev_set;

  pdwt_regfile #(
    .DEPTH (pdwt_pkg::RF_DEPTH),
    .AW    (pdwt_pkg::RF_AW),
    .DW    (pdwt_pkg::REG_DW)
  ) u_regs (
    .CLK      (CLK),
    .ARST_N   (ARST_N),
    .wr_en    (REG_WR && in_win_area),
    .wr_idx   (rf_idx),
    .wr_data  (REG_WDATA),
    .wr_mask  (slot_mask),
    .rd_en    (REG_RD),
    .rd_local (in_win_area),
    .rd_idx   (rf_idx),
    .ext_data (ext_word),
    .rd_data  (REG_RDATA),
    .words    (words)
  );

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_reg <= pdwt_pkg::ST_IDLE;
      ad_reg <= '0;
      ready_reg <= 1'b1;
      mem_req_reg <= 1'b0;
      mem_addr_reg <= '0;
      pte_reg <= '0;
      rsp_reg <= '{addr: '0, status: pdwt_pkg::RSP_OK};
      rsp_valid_reg <= 1'b0;
      sticky_reg <= 3'b000;
    end else begin
      state_reg <= state_next;
      ad_reg <= ad_next;
      ready_reg <= ready_next;
      mem_req_reg <= mem_req_next;
      mem_addr_reg <= mem_addr_next;
      pte_reg <= pte_next;
      rsp_reg <= rsp_next;
      rsp_valid_reg <= rsp_valid_next;
      sticky_reg <= sticky_next;
    end
  end

  assign REQ_READY = ready_reg;
  assign RSP_VALID = rsp_valid_reg;
  assign RSP_ADDR = rsp_reg.addr;
  assign RSP_STATUS = rsp_reg.status;
  assign MEM_REQ = mem_req_reg;
  assign MEM_ADDR = mem_addr_reg;

  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  wire look_ok = (state_reg == pdwt_pkg::ST_LOOK) && any_hit && sel_mask_ok;
  logic sg_mode_reg;
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sg_mode_reg <= 1'b0;
    end else if (state_reg == pdwt_pkg::ST_LOOK) begin
      sg_mode_reg <= sel.sg;
    end
  end
  wire rsp_ok = rsp_valid_reg && (rsp_reg.status == pdwt_pkg::RSP_OK);

  a_sg_fetch_path: assert property (look_ok && sel.sg |=> MEM_REQ && !RSP_VALID)
    else $error("table window did not fetch a map entry");
  a_direct_no_fetch: assert property (look_ok && !sel.sg |=> RSP_VALID && !MEM_REQ ##1 REQ_READY)
    else $error("direct window did not answer at once");
  a_high_zero: assert property (RSP_VALID |-> RSP_ADDR[39:33] == 7'h00)
    else $error("physical bits 39..33 not zero");
  a_direct_offset: assert property (rsp_ok && !sg_mode_reg |-> RSP_ADDR[19:2] == ad_reg[19:2])
    else $error("direct offset bits wrong");
  a_direct_align: assert property (look_ok && !sel.sg && sel.mask == 12'h003
    |=> RSP_ADDR[21:2] == $past(ad_reg[21:2]))
    else $error("4MB direct window offset wrong");
  a_sg_offset: assert property (rsp_ok && sg_mode_reg |-> RSP_ADDR[12:2] == ad_reg[12:2])
    else $error("page offset not kept");
  a_pte_page: assert property (rsp_ok && sg_mode_reg |-> RSP_ADDR[32:13] == pte_reg[20:1])
    else $error("page number not from entry bits");
  a_pte_index: assert property (MEM_REQ |-> MEM_ADDR[2:0] == 3'b000 && MEM_ADDR[9:3] == ad_reg[19:13])
    else $error("map entry address wrong");
  a_invalid_pte: assert property (ack_take && !pte_valid
    |=> RSP_VALID && RSP_STATUS == pdwt_pkg::RSP_INVALID && sticky_reg[0])
    else $error("invalid entry not reported");
  a_miss_report: assert property ((state_reg == pdwt_pkg::ST_LOOK) && !any_hit
    |=> RSP_VALID && RSP_STATUS == pdwt_pkg::RSP_MISS)
    else $error("miss not reported");
  a_unsup_mask: assert property ((state_reg == pdwt_pkg::ST_LOOK) && any_hit && !sel_mask_ok
    |=> RSP_STATUS == pdwt_pkg::RSP_UNSUP && !MEM_REQ)
    else $error("bad mask not refused");
  a_rsp_pulse: assert property (RSP_VALID |=> !RSP_VALID && REQ_READY)
    else $error("response not a single pulse");
  a_mem_req_pulse: assert property (MEM_REQ |=> !MEM_REQ)
    else $error("map entry request not a single pulse");
  a_mem_in_fetch: assert property (MEM_REQ |-> state_reg == pdwt_pkg::ST_FETCH)
    else $error("map entry request outside fetch");
  a_sg_valid: assert property (ack_take && pte_valid
    |=> RSP_VALID && RSP_STATUS == pdwt_pkg::RSP_OK)
    else $error("valid entry not answered");
  a_direct_base: assert property (rsp_ok && !sg_mode_reg && sel.mask == 12'h000
    |-> RSP_ADDR[32:20] == sel.tbase[22:10])
    else $error("direct base bits wrong");
  a_accept_busy: assert property (REQ_VALID && REQ_READY |=> !REQ_READY)
    else $error("ready not lowered after accept");
  a_busy_refuse: assert property (state_reg != pdwt_pkg::ST_IDLE |-> !REQ_READY)
    else $error("ready high while busy");

  c_direct_ok: cover property (rsp_ok && !sg_mode_reg);
  c_sg_ok: cover property (rsp_ok && sg_mode_reg);
  c_sg_invalid: cover property (RSP_VALID && RSP_STATUS == pdwt_pkg::RSP_INVALID);
  c_miss: cover property (RSP_VALID && RSP_STATUS == pdwt_pkg::RSP_MISS);
  c_unsup: cover property (RSP_VALID && RSP_STATUS == pdwt_pkg::RSP_UNSUP);

endmodule

// ===== rtl/pdwt_pkg.sv
// shared constants and types of the pci dma window translator
package pdwt_pkg;

  localparam int NUM_WIN = 4;
  localparam int REG_AW = 8;
  localparam int REG_DW = 32;
  localparam int RF_DEPTH = 16;
  localparam int RF_AW = 4;
  localparam int PCI_AW = 32;
  localparam int PHYS_W = 40;
  localparam int MEM_AW = 34;
  localparam int MEM_DW = 64;

  // register map, window w slot at w * 0x10
  localparam logic [REG_AW-1:0] OFF_WIN_BASE = 8'h00;
  localparam logic [REG_AW-1:0] OFF_WIN_STRIDE = 8'h10;
  localparam logic [REG_AW-1:0] OFF_STATUS = 8'h40;
  localparam logic [REG_AW-1:0] OFF_LAST_ADDR = 8'h44;
  localparam logic [1:0] SLOT_WBASE = 2'h0;
  localparam logic [1:0] SLOT_WMASK = 2'h1;
  localparam logic [1:0] SLOT_TBASE = 2'h2;

  // field positions
  localparam int WB_EN_BIT = 0;
  localparam int WB_SG_BIT = 1;
  localparam int WIN_MSB = 31;
  localparam int WIN_LSB = 20;
  localparam int TB_REG_LSB = 8;
  localparam int TB_ADDR_LSB = 10;
  localparam int PAGE_LSB = 13;
  localparam int PTE_VALID_BIT = 0;
  localparam int PTE_PAGE_MSB = 21;
  localparam int PTE_PAGE_LSB = 1;
  localparam int PHYS_ZERO_MSB = 39;
  localparam int PHYS_ZERO_LSB = 33;

  // writable bits and reset values
  localparam logic [REG_DW-1:0] WMASK_WBASE = 32'hfff00003;
  localparam logic [REG_DW-1:0] WMASK_WMASK = 32'hfff00000;
  localparam logic [REG_DW-1:0] WMASK_TBASE = 32'hffffff00;
  localparam logic [REG_DW-1:0] RST_WORD = 32'h00000000;

  // status register bits
  localparam int ST_BUSY = 0;
  localparam int ST_INVALID = 1;
  localparam int ST_MISS = 2;
  localparam int ST_UNSUP = 3;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_LOOK  = 2'b01,
    ST_FETCH = 2'b11,
    ST_DONE  = 2'b10
  } pdwt_state_e;

  typedef enum logic [1:0] {
    RSP_OK      = 2'b00,
    RSP_MISS    = 2'b01,
    RSP_INVALID = 2'b10,
    RSP_UNSUP   = 2'b11
  } pdwt_rsp_e;

  typedef struct packed {
    logic [11:0] base;
    logic        en;
    logic        sg;
    logic [11:0] mask;
    logic [23:0] tbase;
  } pdwt_win_s;

  typedef struct packed {
    logic [PHYS_W-1:0] addr;
    pdwt_rsp_e         status;
  } pdwt_rsp_s;

endpackage

// ===== rtl/pdwt_regfile.sv
// window register storage with registered bus read port
`timescale 1ns/10ps
module pdwt_regfile #(
  parameter int DEPTH = 16,
  parameter int AW    = 4,
  parameter int DW    = 32
) (
  input  wire logic                    CLK,
  input  wire logic                    ARST_N,
  input  wire logic                    wr_en,
  input  wire logic [AW-1:0]           wr_idx,
  input  wire logic [DW-1:0]           wr_data,
  input  wire logic [DW-1:0]           wr_mask,
  input  wire logic                    rd_en,
  input  wire logic                    rd_local,
  input  wire logic [AW-1:0]           rd_idx,
  input  wire logic [DW-1:0]           ext_data,
  output logic      [DW-1:0]           rd_data,
  output logic      [DEPTH-1:0][DW-1:0] words
);

  logic [DEPTH-1:0][DW-1:0] mem_reg;
  logic [DW-1:0]            rd_data_reg;
  logic [DW-1:0]            rd_data_next;

  // zero outside the cycle after a read
  assign rd_data_next = rd_en ? (rd_local ? mem_reg[rd_idx] : ext_data) : '0;
  assign rd_data = rd_data_reg;
  assign words = mem_reg;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      mem_reg <= '0;
      rd_data_reg <= '0;
    end else begin
      rd_data_reg <= rd_data_next;
      if (wr_en) begin
        mem_reg[wr_idx] <= (mem_reg[wr_idx] & ~wr_mask) | (wr_data & wr_mask);
      end
    end
  end

endmodule

// ===== verif/pdwt_mem_model.sv
// partner model of the memory side answering map entry reads
`timescale 1ns/10ps
module pdwt_mem_model (
  input  wire logic        CLK,
  input  wire logic        ARST_N,
  input  wire logic        MEM_REQ,
  input  wire logic [3:0]  ACK_DELAY,
  input  wire logic [63:0] PTE,
  output logic             MEM_ACK,
  output logic      [63:0] MEM_RDATA
);
  logic        busy_reg;
  logic [3:0]  cnt_reg;
  logic [63:0] last_reg;

  // answer after ACK_DELAY idle cycles, data line holds the inverse of the last answer outside the answer
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      busy_reg  <= 1'b0;
      cnt_reg   <= 4'h0;
      last_reg  <= 64'h0;
      MEM_ACK   <= 1'b0;
      MEM_RDATA <= 64'h0;
    end else begin
      MEM_ACK   <= 1'b0;
      MEM_RDATA <= ~last_reg;
      if (MEM_REQ) begin
        busy_reg <= 1'b1;
        cnt_reg  <= ACK_DELAY;
      end else if (busy_reg && cnt_reg != 4'h0) begin
        cnt_reg <= cnt_reg - 4'h1;
      end else if (busy_reg) begin
        busy_reg  <= 1'b0;
        MEM_ACK   <= 1'b1;
        MEM_RDATA <= PTE;
        last_reg  <= PTE;
      end
    end
  end
endmodule

// ===== verif/pci_dma_window_translate_test.sv
// self-checking bench of the pci dma window translator
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin error_cnt++; \
  $display("[FAIL] %s expected %h seen %h", nm, ex, gt); end end
module pci_dma_window_translate_test;
  logic        CLK, ARST_N, REG_WR, REG_RD, REQ_VALID, REQ_READY, RSP_VALID, MEM_REQ, MEM_ACK;
  logic [7:0]  REG_ADDR;
  logic [31:0] REG_WDATA, REG_RDATA, REQ_ADDR, rd;
  logic [39:0] RSP_ADDR, sa;
  logic [1:0]  RSP_STATUS, sst;
  logic [33:0] MEM_ADDR, smaddr;
  logic [63:0] MEM_RDATA, pte;
  logic [3:0]  ack_delay;
  int          error_cnt, cmp_count, cyc, smreq;

  pdwt_top DUT (.CLK(CLK), .ARST_N(ARST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .REQ_VALID(REQ_VALID), .REQ_ADDR(REQ_ADDR), .REQ_READY(REQ_READY),
    .RSP_VALID(RSP_VALID), .RSP_ADDR(RSP_ADDR), .RSP_STATUS(RSP_STATUS), .MEM_REQ(MEM_REQ),
    .MEM_ADDR(MEM_ADDR), .MEM_ACK(MEM_ACK), .MEM_RDATA(MEM_RDATA));
  pdwt_mem_model u_mem (.CLK(CLK), .ARST_N(ARST_N), .MEM_REQ(MEM_REQ), .ACK_DELAY(ack_delay), .PTE(pte),
    .MEM_ACK(MEM_ACK), .MEM_RDATA(MEM_RDATA));

  initial CLK = 1'b0;
  always #5 CLK = ~CLK;

  always @(posedge CLK) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    REG_WR    <= 1'b1;
    REG_ADDR  <= a;
    REG_WDATA <= d;
    @(posedge CLK);
    REG_WR <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a);
    @(posedge CLK);
    REG_RD   <= 1'b1;
    REG_ADDR <= a;
    @(posedge CLK);
    REG_RD <= 1'b0;
    #1 rd = REG_RDATA;
  endtask

  task automatic set_win(input int w, input logic [11:0] b, input logic en, input logic sg,
                         input logic [11:0] m, input logic [31:0] t);
    reg_wr(8'(w * 16), {b, 18'h0, sg, en});
    reg_wr(8'(w * 16 + 4), {m, 20'h0});
    reg_wr(8'(w * 16 + 8), t);
  endtask

  task automatic xlate(input logic [31:0] ad);
    int n;
    n     = 0;
    smreq = 0;
    @(posedge CLK);
    REQ_VALID <= 1'b1;
    REQ_ADDR  <= ad;
    @(posedge CLK);
    while (REQ_READY !== 1'b1) @(posedge CLK);
    REQ_VALID <= 1'b0;
    do begin
      @(negedge CLK);
      n++;
      if (MEM_REQ === 1'b1) begin
        smreq++;
        smaddr = MEM_ADDR;
      end
    end while (RSP_VALID !== 1'b1 && n < 40);
    `CHK("response seen", 1'b1, RSP_VALID)
    sa  = RSP_ADDR;
    sst = RSP_STATUS;
  endtask

  function automatic logic [39:0] exp_dir(logic [31:0] ad, logic [11:0] m, logic [31:0] t);
    logic [33:0] a;
    a = {t[31:18], 20'h0} | {2'h0, ad[31:20] & m, ad[19:2], 2'h0};
    return {7'h0, a[32:0]};
  endfunction

  function automatic logic [33:0] exp_ent(logic [31:0] ad, logic [11:0] m, logic [31:0] t);
    return {t[31:8], 10'h0} | {12'h0, ad[31:20] & m, ad[19:13], 3'h0};
  endfunction

  task automatic t_regs();
    reg_wr(8'h10, 32'hffffffff);
    reg_rd(8'h10);
    `CHK("window base", 32'hfff00003, rd)
    reg_wr(8'h14, 32'hffffffff);
    reg_rd(8'h14);
    `CHK("window mask", 32'hfff00000, rd)
    reg_wr(8'h18, 32'hffffffff);
    reg_rd(8'h18);
    `CHK("translated base", 32'hffffff00, rd)
    reg_wr(8'h1c, 32'hffffffff);
    reg_rd(8'h1c);
    `CHK("unmapped", 32'h0, rd)
    set_win(1, 12'h0, 1'b0, 1'b0, 12'h0, 32'h0);
    $display("test registers done");
  endtask

  task automatic t_direct();
    logic [11:0] m, b;
    logic [31:0] t, ad;
    for (int k = 0; k <= 13; k++) begin
      m  = (k == 13) ? 12'h3 : 12'((1 << k) - 1);
      b  = 12'ha5a & ~m;
      t  = 32'hfffc0000 & ~32'({m, 18'h0});
      t  = (k == 13) ? (t | 32'h00040000) : t;
      ad = {b | (12'h3c3 & m), 20'habcdf};
      set_win(0, b, 1'b1, 1'b0, m, t);
      xlate(ad);
      `CHK("direct status", 2'h0, sst)
      `CHK("direct fetch", 0, smreq)
      `CHK("direct addr", exp_dir(ad, m, t), sa)
      `CHK("direct top", 7'h0, sa[39:33])
    end
    $display("test direct done");
  endtask

  task automatic t_miss();
    set_win(0, 12'h100, 1'b0, 1'b0, 12'h0, 32'h0);
    xlate(32'h10000000);
    `CHK("disabled", 2'h1, sst)
    set_win(0, 12'h100, 1'b1, 1'b0, 12'h0, 32'h0);
    xlate(32'h10100000);
    `CHK("above mask", 2'h1, sst)
    reg_rd(8'h40);
    `CHK("miss sticky", 1'b1, rd[2])
    reg_wr(8'h40, 32'h4);
    reg_rd(8'h40);
    `CHK("miss cleared", 32'h0, rd)
    set_win(1, 12'h101, 1'b1, 1'b0, 12'h0, 32'h00400000);
    xlate(32'h10100010);
    `CHK("second window", 40'h0001000010, sa)
    reg_rd(8'h44);
    `CHK("last address", 32'h00400004, rd)
    set_win(1, 12'h0, 1'b0, 1'b0, 12'h0, 32'h0);
    $display("test miss done");
  endtask

  task automatic t_unsup();
    set_win(0, 12'h100, 1'b1, 1'b0, 12'h005, 32'h0);
    xlate(32'h10000000);
    `CHK("unsupported", 2'h3, sst)
    `CHK("unsupported fetch", 0, smreq)
    $display("test unsupported done");
  endtask

  task automatic t_sg();
    logic [11:0] m, b;
    logic [31:0] t, ad;
    for (int i = 0; i < 3; i++) begin
      m         = (i == 0) ? 12'h000 : (i == 1) ? 12'h0ff : 12'hfff;
      b         = 12'h800 & ~m;
      t         = 32'h12345600 & ~32'({m, 8'h0});
      ad        = {b | (12'h5a5 & m), 20'h7e6a8};
      ack_delay = 4'(i * 3);
      pte       = 64'h003abcd3;
      set_win(0, b, 1'b1, 1'b1, m, t);
      xlate(ad);
      `CHK("entry fetch", 1, smreq)
      `CHK("entry addr", exp_ent(ad, m, t), smaddr)
      `CHK("table addr", {7'h0, pte[20:1], ad[12:2], 2'h0}, sa)
      `CHK("table status", 2'h0, sst)
      `CHK("table top", 7'h0, sa[39:33])
    end
    pte = 64'h003abcd2;
    xlate(ad);
    `CHK("invalid entry", 2'h2, sst)
    reg_rd(8'h40);
    `CHK("invalid sticky", 1'b1, rd[1])
    $display("test table done");
  endtask

  initial begin
    ARST_N    = 1'b0;
    REG_WR    = 1'b0;
    REG_RD    = 1'b0;
    REG_ADDR  = 8'h0;
    REG_WDATA = 32'h0;
    REQ_VALID = 1'b0;
    REQ_ADDR  = 32'h0;
    pte       = 64'h0;
    ack_delay = 4'h0;
    error_cnt = 0;
    cmp_count = 0;
    cyc       = 0;
    repeat (12) @(posedge CLK);
    ARST_N <= 1'b1;
    t_regs();
    t_direct();
    t_miss();
    t_unsup();
    t_sg();
    complete_run();
  end
endmodule
